/* File: flash_status_pkg.sv */
package flash_status_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int BANK_W = 2;
  localparam int DATA_W = 16;
  localparam int STAT_W = 8;
  localparam int CNT_W = 4;

  // ----------------------------------------------------------------
  // Status word layout
  // ----------------------------------------------------------------
  localparam int READY_BIT = 7;
  localparam int ESUSP_BIT = 6;
  localparam int EERR_BIT = 5;
  localparam int PERR_BIT = 4;
  localparam int RSVD_BIT = 3;
  localparam int PSUSP_BIT = 2;
  localparam int LOCK_BIT = 1;
  localparam int BANK_BIT = 0;
  localparam logic [STAT_W-1:0] STATUS_RESET = 8'h80;
  localparam logic [STAT_W-1:0] VALID_WHEN_BUSY = 8'h81;

  // ----------------------------------------------------------------
  // Link commands (codes arbitrary)
  // ----------------------------------------------------------------
  typedef logic [7:0] cmd_code_t;
  localparam cmd_code_t CMD_NONE = 8'h00;
  localparam cmd_code_t CMD_STATUS_READ = 8'h01;
  localparam cmd_code_t CMD_CLEAR_STATUS = 8'h02;
  localparam cmd_code_t CMD_ERASE_SUSPEND = 8'h03;
  localparam cmd_code_t CMD_ERASE_RESUME = 8'h04;
  localparam cmd_code_t CMD_PROG_SUSPEND = 8'h05;
  localparam cmd_code_t CMD_PROG_RESUME = 8'h06;

  // ----------------------------------------------------------------
  // Read wait-counter loads in clock cycles; the answer comes two cycles after the count
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] SYNC_WAIT_CYCLES = 4'hD;
  localparam logic [CNT_W-1:0] ASYNC_WAIT_CYCLES = 4'h1;

  // ----------------------------------------------------------------
  // Controller APB map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam int CMD_BANK_LSB = 8;
  localparam int CTRL_SYNC_BIT = 0;
  localparam int STAT_BUSY_BIT = 8;
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;
  localparam logic [STAT_W-1:0] ERROR_BITS = 8'h32;

endpackage

/* File: flash_link_if.sv */
`timescale 1ns/10ps
interface flash_link_if;
  import flash_status_pkg::*;

  logic cmd_valid;
  cmd_code_t cmd_code;
  logic [BANK_W-1:0] cmd_bank;
  logic rd_req;
  logic rd_sync;
  logic rd_valid;
  logic [DATA_W-1:0] rd_data;

  // Flash end answers reads
  modport device (
    input cmd_valid,
    input cmd_code,
    input cmd_bank,
    input rd_req,
    input rd_sync,
    output rd_valid,
    output rd_data
  );

  // Controller end issues commands and reads
  modport host (
    output cmd_valid,
    output cmd_code,
    output cmd_bank,
    output rd_req,
    output rd_sync,
    input rd_valid,
    input rd_data
  );
endinterface

/* File: read_latency_timer.sv */
`timescale 1ns/10ps
module read_latency_timer
  import flash_status_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [CNT_W-1:0] load_count,
  output logic done
);

  logic [CNT_W-1:0] count;

  // Counts down the load value, pulses done as it expires
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= '0;
      done <= 1'b0;
    end
    else if (start)
    begin
      count <= load_count;
      done <= 1'b0;
    end
    else
    begin
      done <= (count == 4'h1);
      if (count != '0)
        count <= count - 4'h1;
    end
  end

endmodule // read_latency_timer

/* File: flash_status_device.sv */
// Functional notes
// RL1: Host issues status-read before each status read
// RL2: Clear-status command clears latched error flags
// RL3: Status read works in sync and async modes
// RL4: Only low eight bits meaningful; upper undefined
// RL5: Ready flag high exactly when nothing runs
// RL6: Bits six to one invalid while busy
// RL7: Bank flag stays valid while busy
// RL8: Bank flag: busy 0 here, 1 elsewhere
// RL9: Erase-suspend flag cleared by erase resume
// RL10: After suspend, host polls until ready
// RL11: Erase error holds latest erase result
// RL12: Program error holds latest program result
// RL13: Reset shows ready one, all else zero
// RL14: Program-suspend flag cleared by program resume
// RL15: Locked-sector flag on locked target failure
// RL16: Reserved bit always reads zero
`timescale 1ns/10ps
module flash_status_device
  import flash_status_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  flash_link_if.device link,
  input wire logic core_busy,
  input wire logic [BANK_W-1:0] core_bank,
  input wire logic erase_done,
  input wire logic erase_fail,
  input wire logic program_done,
  input wire logic program_fail,
  input wire logic lock_fail,
  input wire logic erase_suspended_evt,
  input wire logic program_suspended_evt,
  input wire logic [DATA_W-1:0] array_data,
  output logic erase_suspend_req,
  output logic erase_resume_req,
  output logic program_suspend_req,
  output logic program_resume_req,
  output logic [STAT_W-1:0] status_byte
);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic cmd_status_read;
  logic cmd_clear;
  logic cmd_erase_resume;
  logic cmd_prog_resume;

  assign cmd_status_read = link.cmd_valid && (link.cmd_code == CMD_STATUS_READ);
  assign cmd_clear = link.cmd_valid && (link.cmd_code == CMD_CLEAR_STATUS);
  assign cmd_erase_resume = link.cmd_valid && (link.cmd_code == CMD_ERASE_RESUME);
  assign cmd_prog_resume = link.cmd_valid && (link.cmd_code == CMD_PROG_RESUME);

  // ----------------------------------------------------------------
  // Latched flags
  // ----------------------------------------------------------------
  logic erase_suspended_flag;
  logic erase_error_flag;
  logic program_error_flag;
  logic program_suspended_flag;
  logic locked_sector_error_flag;
  logic [BANK_W-1:0] addressed_bank;

  // Erase suspension; a new suspension wins over a resume
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      erase_suspended_flag <= 1'b0; // RL13
    else if (erase_suspended_evt)
      erase_suspended_flag <= 1'b1;
    else if (cmd_erase_resume)
      erase_suspended_flag <= 1'b0; // RL9
  end

  // Program suspension; a new suspension wins over a resume
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      program_suspended_flag <= 1'b0; // RL13
    else if (program_suspended_evt)
      program_suspended_flag <= 1'b1;
    else if (cmd_prog_resume)
      program_suspended_flag <= 1'b0; // RL14
  end

  // Erase result; completion wins over clear-status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      erase_error_flag <= 1'b0; // RL13
    else if (erase_done)
      erase_error_flag <= erase_fail; // RL11
    else if (cmd_clear)
      erase_error_flag <= 1'b0; // RL2
  end

  // Program result; completion wins over clear-status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      program_error_flag <= 1'b0; // RL13
    else if (program_done)
      program_error_flag <= program_fail; // RL12
    else if (cmd_clear)
      program_error_flag <= 1'b0; // RL2
  end

  // Locked-sector result of the latest program or erase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      locked_sector_error_flag <= 1'b0; // RL13
    else if (erase_done || program_done)
      locked_sector_error_flag <= lock_fail; // RL15
    else if (cmd_clear)
      locked_sector_error_flag <= 1'b0; // RL2
  end

  // Bank named by the latest command
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      addressed_bank <= '0;
    else if (link.cmd_valid)
      addressed_bank <= link.cmd_bank;
  end

  // ----------------------------------------------------------------
  // Status word assembly
  // ----------------------------------------------------------------
  logic device_ready_flag;
  logic bank_busy_select_flag;
  logic [STAT_W-1:0] next_status;

  assign device_ready_flag = !core_busy; // RL5
  // Busy elsewhere reads one, busy here zero, idle zero
  assign bank_busy_select_flag = core_busy && (core_bank != addressed_bank); // RL7 RL8

  always_comb
  begin
    next_status = '0;
    next_status[READY_BIT] = device_ready_flag;
    next_status[ESUSP_BIT] = erase_suspended_flag;
    next_status[EERR_BIT] = erase_error_flag;
    next_status[PERR_BIT] = program_error_flag;
    next_status[RSVD_BIT] = 1'b0; // RL16
    next_status[PSUSP_BIT] = program_suspended_flag;
    next_status[LOCK_BIT] = locked_sector_error_flag;
    next_status[BANK_BIT] = bank_busy_select_flag;
  end

  // Registered copy for the core side
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_byte <= STATUS_RESET; // RL13
    else
      status_byte <= next_status;
  end

  // ----------------------------------------------------------------
  // Suspend and resume requests to the core
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      erase_suspend_req <= 1'b0;
      erase_resume_req <= 1'b0;
      program_suspend_req <= 1'b0;
      program_resume_req <= 1'b0;
    end
    else
    begin
      erase_suspend_req <= link.cmd_valid && (link.cmd_code == CMD_ERASE_SUSPEND);
      erase_resume_req <= cmd_erase_resume;
      program_suspend_req <= link.cmd_valid && (link.cmd_code == CMD_PROG_SUSPEND);
      program_resume_req <= cmd_prog_resume;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic status_armed;
  logic read_pending;
  logic read_start;
  logic read_done;

  assign read_start = link.rd_req && !read_pending;

  // Latency counter picks the wait for the selected read mode
  read_latency_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(read_start),
    .load_count(link.rd_sync ? SYNC_WAIT_CYCLES : ASYNC_WAIT_CYCLES), // RL3
    .done(read_done)
  );

  // One read in flight at a time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      read_pending <= 1'b0;
    else if (read_start)
      read_pending <= 1'b1;
    else if (read_done)
      read_pending <= 1'b0;
  end

  // A status-read command arms exactly one read; a new command wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_armed <= 1'b0;
    else if (cmd_status_read)
      status_armed <= 1'b1; // RL1
    else if (read_done)
      status_armed <= 1'b0; // RL1
  end

  // Answer: armed reads give status in the low byte with the upper byte zero; other reads give array_data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link.rd_valid <= 1'b0;
      link.rd_data <= '0;
    end
    else
    begin
      link.rd_valid <= read_done;
      if (read_done)
      begin
        if (status_armed)
          link.rd_data <= {{(DATA_W-STAT_W){1'b0}}, next_status}; // RL4 RL3
        else
          link.rd_data <= array_data;
      end
    end
  end

endmodule // flash_status_device

/* File: flash_status_host.sv */
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/10ps
module flash_status_host
  import flash_status_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  flash_link_if.host link
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SEND = 4'b0010,
    ST_READ = 4'b0100,
    ST_WAIT = 4'b1000
  } host_state_t;

  host_state_t state;
  cmd_code_t pend_code;
  logic [BANK_W-1:0] pend_bank;
  logic polling;
  logic sync_mode;
  logic [STAT_W-1:0] last_status;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [STAT_W-1:0] rx_status;
  logic finish;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic setup;
  logic wr_en;
  logic mapped;

  assign setup = psel && !penable && !pready;
  assign wr_en = psel && penable && pready && pwrite;
  assign mapped = (paddr == ADDR_CMD) || (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS)
                  || (paddr == ADDR_IRQ_STAT) || (paddr == ADDR_IRQ_MASK);

  // Zero-wait answer, read data fetched in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= '0;
      if (setup && !pwrite)
      begin
        case (paddr)
          ADDR_CTRL: prdata[CTRL_SYNC_BIT] <= sync_mode;
          ADDR_STATUS: prdata[STAT_BUSY_BIT:0] <= {(state != ST_IDLE), last_status};
          ADDR_IRQ_STAT: prdata[IRQ_W-1:0] <= irq_status;
          ADDR_IRQ_MASK: prdata[IRQ_W-1:0] <= irq_mask;
          default: prdata <= '0;
        endcase
      end
    end
  end

  // Read mode and interrupt mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_mode <= 1'b0;
      irq_mask <= '0;
    end
    else if (wr_en && (paddr == ADDR_CTRL))
      sync_mode <= pwdata[CTRL_SYNC_BIT];
    else if (wr_en && (paddr == ADDR_IRQ_MASK))
      irq_mask <= pwdata[IRQ_W-1:0];
  end

  // Sticky events; a new event wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status <= '0;
    else
    begin
      if (wr_en && (paddr == ADDR_IRQ_STAT))
        irq_status <= irq_status & ~pwdata[IRQ_W-1:0];
      if (finish)
      begin
        irq_status[IRQ_DONE_BIT] <= 1'b1;
        if ((rx_status & ERROR_BITS) != '0)
          irq_status[IRQ_ERR_BIT] <= 1'b1;
      end
    end
  end

  // Level interrupt from unmasked sticky bits; a set mask bit hides its event
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= (irq_status & ~irq_mask) != '0;
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  logic ready_seen;

  // Upper bits dropped; bits six to one zeroed while busy
  always_comb
  begin
    rx_status = link.rd_data[STAT_W-1:0]; // RL4
    if (!rx_status[READY_BIT])
      rx_status = rx_status & VALID_WHEN_BUSY; // RL6
  end

  assign ready_seen = rx_status[READY_BIT];
  assign finish = (state == ST_WAIT) && link.rd_valid && !(polling && !ready_seen);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_IDLE;
      pend_code <= CMD_NONE;
      pend_bank <= '0;
      polling <= 1'b0;
      last_status <= STATUS_RESET;
      link.cmd_valid <= 1'b0;
      link.cmd_code <= CMD_NONE;
      link.cmd_bank <= '0;
      link.rd_req <= 1'b0;
      link.rd_sync <= 1'b0;
    end
    else
    begin
      link.cmd_valid <= 1'b0;
      link.rd_req <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (wr_en && (paddr == ADDR_CMD))
          begin
            pend_code <= pwdata[7:0];
            pend_bank <= pwdata[CMD_BANK_LSB +: BANK_W];
            polling <= (pwdata[7:0] == CMD_ERASE_SUSPEND)
                       || (pwdata[7:0] == CMD_PROG_SUSPEND); // RL10
            state <= ST_SEND;
          end
        end
        ST_SEND:
        begin
          // Idle one cycle after a command so every strobe stays one cycle
          if (!link.cmd_valid)
          begin
            link.cmd_valid <= 1'b1;
            link.cmd_code <= pend_code;
            link.cmd_bank <= pend_bank;
            if ((pend_code == CMD_STATUS_READ) || polling)
            begin
              pend_code <= CMD_STATUS_READ; // RL1
              state <= (pend_code == CMD_STATUS_READ) ? ST_READ : ST_SEND;
            end
            else
              state <= ST_IDLE;
          end
        end
        ST_READ:
        begin
          link.rd_req <= 1'b1;
          link.rd_sync <= sync_mode;
          state <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (link.rd_valid)
          begin
            last_status <= rx_status;
            if (polling && !ready_seen)
              state <= ST_SEND; // RL10 RL1
            else
            begin
              polling <= 1'b0;
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // flash_status_host

/* File: flash_link_properties.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Link checker
// ----------------------------------------
module flash_link_properties
  import flash_status_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cmd_valid,
  input wire cmd_code_t cmd_code,
  input wire logic [BANK_W-1:0] cmd_bank,
  input wire logic rd_req,
  input wire logic rd_sync,
  input wire logic rd_valid,
  input wire logic [DATA_W-1:0] rd_data
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Answer timing in both read modes
  a_async_latency: assert property (rd_req && !rd_sync |=> !rd_valid ##1 !rd_valid ##1 rd_valid)
    else $error("async read answer not three cycles after request");
  a_sync_latency: assert property (rd_req && rd_sync |-> ##15 rd_valid)
    else $error("sync read answer not fifteen cycles after request");
  a_answer_cause: assert property (rd_valid |-> ($past(rd_req, 3) && !$past(rd_sync, 3))
    || ($past(rd_req, 15) && $past(rd_sync, 15)))
    else $error("read answer without matching request");
  // Host ordering on the link
  a_status_first: assert property (rd_req |-> $past(cmd_valid)
    && $past(cmd_code) == CMD_STATUS_READ)
    else $error("read not preceded by status read command");
  a_cmd_single: assert property (cmd_valid |=> !cmd_valid)
    else $error("command strobe longer than one cycle");
  // Content of the status answer
  a_reserved_zero: assert property (rd_valid |-> !rd_data[RSVD_BIT])
    else $error("reserved status bit set");
  a_upper_zero: assert property (rd_valid |-> rd_data[15:8] == 8'h00)
    else $error("upper answer byte not zero");
  a_ready_bank: assert property (rd_valid && rd_data[READY_BIT] |-> !rd_data[BANK_BIT])
    else $error("bank flag set while ready");
  a_clear_errors: assert property (cmd_valid && cmd_code == CMD_CLEAR_STATUS ##[1:30]
    rd_req && !rd_sync |-> ##3 rd_valid && (rd_data[STAT_W-1:0] & ERROR_BITS) == 8'h00)
    else $error("error flags survive clear");
endmodule // flash_link_properties

/* File: flash_operation_status_register_tb.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Controller plus flash status bench
// ----------------------------------------
module flash_operation_status_register_tb
  import flash_status_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, core_busy, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [BANK_W-1:0] core_bank;
  logic [6:0] ev;
  logic [3:0] reqs, req_seen;
  logic [STAT_W-1:0] status_byte;
  int n_errors, cmp_count, cyc, i, k;
  cmd_code_t codes [4] = '{CMD_ERASE_SUSPEND, CMD_ERASE_RESUME, CMD_PROG_SUSPEND,
    CMD_PROG_RESUME};
  logic [6:0] evts [4] = '{7'h02, 7'h00, 7'h01, 7'h00};
  logic [31:0] exps [4] = '{32'hC0, 32'h80, 32'h84, 32'h80};

  flash_link_if link ();
  flash_status_device flash_status_device_i (.pclk(pclk), .presetn(presetn), .link(link),
    .core_busy(core_busy), .core_bank(core_bank), .erase_done(ev[6]), .erase_fail(ev[5]),
    .program_done(ev[4]), .program_fail(ev[3]), .lock_fail(ev[2]),
    .erase_suspended_evt(ev[1]), .program_suspended_evt(ev[0]), .array_data(16'hA5C3),
    .erase_suspend_req(reqs[0]), .erase_resume_req(reqs[1]), .program_suspend_req(reqs[2]),
    .program_resume_req(reqs[3]), .status_byte(status_byte));
  flash_status_host flash_status_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .link(link));
  flash_link_properties flash_link_properties_i (.pclk(pclk), .presetn(presetn),
    .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code), .cmd_bank(link.cmd_bank),
    .rd_req(link.rd_req), .rd_sync(link.rd_sync), .rd_valid(link.rd_valid),
    .rd_data(link.rd_data));

  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Hang guard and suspend and resume request capture
  always @(posedge pclk)
  begin
    cyc++;
    req_seen <= req_seen | reqs;
    if (cyc == 6000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer, result in v and err
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    v = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Link command, then poll until controller idle and return its status
  task cmd(input cmd_code_t code, input logic [BANK_W-1:0] b);
    int n;
    apb(1'b1, ADDR_CMD, (32'(b) << CMD_BANK_LSB) | 32'(code));
    n = 0;
    do
    begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end
    while (v[STAT_BUSY_BIT] !== 1'b0 && n < 60);
  endtask

  task pulse(input logic [6:0] p);
    ev <= p;
    @(posedge pclk);
    ev <= 7'h00;
    @(posedge pclk);
  endtask

  task report_and_stop;
    if (n_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    core_busy = 1'b0;
    core_bank = 2'h0;
    ev = 7'h00;
    req_seen = 4'h0;
    n_errors = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (16) @(posedge pclk);
    check(32'(status_byte), 32'h80);
    presetn <= 1'b1;
    @(posedge pclk);
    cmd(CMD_STATUS_READ, 2'h0);
    check(v, 32'h80);
    apb(1'b0, 8'h14, 32'h0);
    check({v[31:1], err}, 32'h1);
    pulse(7'h18);
    cmd(CMD_STATUS_READ, 2'h0);
    check(v, 32'h90);
    check(32'(status_byte), 32'h90);
    // Interrupt raised, masked, unmasked, cleared
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    check({v[31:1], irq}, 32'h3);
    apb(1'b1, ADDR_IRQ_MASK, 32'h3);
    apb(1'b0, ADDR_IRQ_MASK, 32'h0);
    check({v[31:1], irq}, 32'h2);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    check({v[31:1], irq}, 32'h3);
    apb(1'b1, ADDR_IRQ_STAT, 32'h3);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    check({v[31:1], irq}, 32'h0);
    // Latest result flags
    pulse(7'h64);
    cmd(CMD_STATUS_READ, 2'h0);
    check(v, 32'hB2);
    pulse(7'h40);
    cmd(CMD_STATUS_READ, 2'h0);
    check(v & 32'h30, 32'h10);
    cmd(CMD_CLEAR_STATUS, 2'h0);
    cmd(CMD_STATUS_READ, 2'h0);
    check(v, 32'h80);
    // Synchronous read mode
    apb(1'b1, ADDR_CTRL, 32'h1);
    pulse(7'h18);
    cmd(CMD_STATUS_READ, 2'h0);
    check(v, 32'h90);
    cmd(CMD_CLEAR_STATUS, 2'h0);
    cmd(CMD_STATUS_READ, 2'h0);
    check(v, 32'h80);
    // Busy: ready low, bank flag by addressed bank, stale error hidden
    pulse(7'h18);
    core_busy <= 1'b1;
    core_bank <= 2'h2;
    cmd(CMD_STATUS_READ, 2'h2);
    check(v, 32'h0);
    cmd(CMD_STATUS_READ, 2'h1);
    check(v, 32'h1);
    cmd(CMD_CLEAR_STATUS, 2'h2);
    check(32'(status_byte), 32'h00);
    // Suspend and resume of erase and program
    for (k = 0; k < 4; k++)
    begin
      core_busy <= ~k[0];
      fork
        cmd(codes[k], 2'h2);
        begin
          for (i = 0; i < 80 && !req_seen[k]; i++)
            @(posedge pclk);
          core_busy <= 1'b0;
          pulse(evts[k]);
        end
      join
      cmd(CMD_STATUS_READ, 2'h2);
      check(v, exps[k]);
      check(32'(req_seen), (32'h1 << (k + 1)) - 32'h1);
    end
    report_and_stop();
  end
endmodule // flash_operation_status_register_tb
